// *** rtl/flash_seq_pkg.sv ***
package flash_seq_pkg;
	// ========================================
	// Opcodes
	localparam logic [7:0] OP_PROGRAM    = 8'h02;
	localparam logic [7:0] OP_PAGE_ERASE = 8'h81;
	localparam logic [7:0] OP_BLK4       = 8'h20;
	localparam logic [7:0] OP_BLK32_A    = 8'h52;
	localparam logic [7:0] OP_BLK32_B    = 8'hd8;
	localparam logic [7:0] OP_CHIP_A     = 8'h60;
	localparam logic [7:0] OP_CHIP_B     = 8'h62;
	localparam logic [7:0] OP_CHIP_C     = 8'hc7;
	localparam logic [7:0] OP_WREN       = 8'h06;
	localparam logic [7:0] OP_WRDI       = 8'h04;
	// ========================================
	// Geometry and timing
	localparam int          PAGE_BYTES    = 256;
	localparam logic [8:0]  PAGE_FULL     = 9'h100;
	localparam logic [7:0]  LAST_IDX      = 8'hff;
	localparam logic [2:0]  HDR_DONE      = 3'h4;
	localparam logic [7:0]  ERASED_BYTE   = 8'hff;
	localparam logic [15:0] ADDR_MASK     = 16'h7fff;
	localparam logic [15:0] BLK4_MASK     = 16'h7000;
	localparam logic [15:0] BLK32_MASK    = 16'h0000;
	localparam int unsigned CLK_FREQ_MHZ  = 125;
	localparam int          FIFO_DEPTH    = 16;
	// ========================================
	// Types
	typedef enum logic [2:0] {
		AOP_PROGRAM    = 3'h0,
		AOP_ERASE_PAGE = 3'h1,
		AOP_ERASE_4K   = 3'h2,
		AOP_ERASE_32K  = 3'h3,
		AOP_ERASE_CHIP = 3'h4
	} array_op_t;
	typedef enum logic [1:0] {
		ST_IDLE = 2'h0,
		ST_FILL = 2'h1,
		ST_WAIT = 2'h3
	} seq_state_t;
	typedef struct packed {
		array_op_t   op;
		logic [15:0] addr;
		logic [7:0]  data;
	} array_cmd_t;
	typedef struct packed {
		logic cs_n;
		logic sck;
		logic mosi;
	} spi_in_t;
	typedef struct packed {
		logic busy;
		logic write_enable_latch;
		logic erase_program_error_flag;
	} status_t;
endpackage : flash_seq_pkg

// *** rtl/spi_flash_program_erase_sequencer.sv ***
`timescale 1ns/1ps
// ========================================
// Command FIFO towards the array
module cmd_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 16
) (
	input  wire logic             sys_clk_i,
	input  wire logic             reset_i,
	input  wire logic             in_valid_i,
	output logic                  in_ready_o,
	input  wire logic [WIDTH-1:0] in_data_i,
	output logic                  out_valid_o,
	input  wire logic             out_ready_i,
	output logic      [WIDTH-1:0] out_data_o
);
	localparam int PW = $clog2(DEPTH);
	typedef struct packed {
		logic [DEPTH-1:0][WIDTH-1:0] mem;
		logic [PW:0]                 wp;
		logic [PW:0]                 rp;
	} fifo_regs_t;
	fifo_regs_t st;
	fifo_regs_t next_st;
	logic       full;
	logic       empty;

	assign empty       = st.wp == st.rp;
	assign full        = (st.wp[PW-1:0] == st.rp[PW-1:0]) && !empty;
	assign in_ready_o  = !full;
	assign out_valid_o = !empty;
	assign out_data_o  = st.mem[st.rp[PW-1:0]];

	always_comb
	begin
		next_st = st;
		if (in_valid_i && !full)
		begin
			next_st.mem[st.wp[PW-1:0]] = in_data_i;
			next_st.wp = st.wp + 1'b1;
		end
		if (out_ready_i && !empty)
			next_st.rp = st.rp + 1'b1;
	end

	always_ff @(posedge sys_clk_i or posedge reset_i)
	begin
		if (reset_i)
			st <= '0;
		else
			st <= next_st;
	end
endmodule : cmd_fifo

// ========================================
// Program / erase sequencer
module spi_flash_program_erase_sequencer #(
	parameter int unsigned PAGE_PROGRAM_TIME_US        = 1000,
	parameter int unsigned SINGLE_BYTE_PROGRAM_TIME_US = 50,
	parameter int unsigned PAGE_ERASE_TIME_US          = 1000,
	parameter int unsigned BLOCK_ERASE_TIME_US         = 20000,
	parameter int unsigned WHOLE_ARRAY_ERASE_TIME_US   = 100000
) (
	input  wire logic                    sys_clk_i,
	input  wire logic                    reset_i,
	input  wire flash_seq_pkg::spi_in_t  spi_i,
	input  wire logic                    array_protect_bit_i,
	input  wire logic                    arr_ready_i,
	input  wire logic                    arr_fail_i,
	output logic                         arr_valid_o,
	output flash_seq_pkg::array_cmd_t    arr_cmd_o,
	output flash_seq_pkg::status_t       status_o
);
	import flash_seq_pkg::*;

	// Cycle counts derived from the times
	localparam logic [31:0] PP_CYC  =
		32'(PAGE_PROGRAM_TIME_US * CLK_FREQ_MHZ);
	localparam logic [31:0] BP_CYC  =
		32'(SINGLE_BYTE_PROGRAM_TIME_US * CLK_FREQ_MHZ);
	localparam logic [31:0] PE_CYC  =
		32'(PAGE_ERASE_TIME_US * CLK_FREQ_MHZ);
	localparam logic [31:0] BLK_CYC =
		32'(BLOCK_ERASE_TIME_US * CLK_FREQ_MHZ);
	localparam logic [31:0] CHP_CYC =
		32'(WHOLE_ARRAY_ERASE_TIME_US * CLK_FREQ_MHZ);

	typedef struct packed {
		seq_state_t                       state;
		logic                             sck_d;
		logic                             cs_d;
		logic [7:0]                       shift;
		logic [2:0]                       bitcnt;
		logic [2:0]                       bytecnt;
		logic [7:0]                       opcode;
		logic [15:0]                      addr;
		logic [7:0]                       page;
		logic [7:0]                       start_lo;
		logic [7:0]                       wptr;
		logic [8:0]                       ndata;
		logic [PAGE_BYTES-1:0]            mask;
		logic [PAGE_BYTES-1:0][7:0]       pbuf;
		array_op_t                        aop;
		logic [7:0]                       idx;
		logic [31:0]                      timer;
		logic                             wr_en;
		logic                             op_err;
	} seq_regs_t;

	seq_regs_t   st;
	seq_regs_t   next_st;
	logic        sck_rise;
	logic        cs_rise;
	logic        cs_fall;
	logic        byte_done;
	logic [7:0]  byte_in;
	logic [7:0]  a;
	logic        busy;
	logic        push;
	logic        fifo_in_ready;
	array_cmd_t  cmd;
	logic        aligned;
	logic        go;
	array_op_t   go_op;
	logic [31:0] go_time;

	assign sck_rise  = spi_i.sck && !st.sck_d && !spi_i.cs_n;
	assign cs_rise   = spi_i.cs_n && !st.cs_d;
	assign cs_fall   = !spi_i.cs_n && st.cs_d;
	assign byte_in   = {st.shift[6:0], spi_i.mosi};
	assign byte_done = sck_rise && (st.bitcnt == 3'h7);
	assign a         = st.start_lo + st.idx;
	assign busy      = st.state != ST_IDLE;
	assign aligned   = st.bitcnt == 3'h0;

	// ========================================
	// Next state
	always_comb
	begin
		next_st = st;
		push    = 1'b0;
		cmd     = '0;
		go      = 1'b0;
		go_op   = AOP_PROGRAM;
		go_time = '0;
		next_st.sck_d = spi_i.sck;
		next_st.cs_d  = spi_i.cs_n;
		if (st.timer != '0)
			next_st.timer = st.timer - 32'h1;
		if (cs_fall)
		begin
			next_st.bitcnt  = '0;
			next_st.bytecnt = '0;
			next_st.ndata   = '0;
			next_st.opcode  = '0;
			if (!busy)
				next_st.mask = '0;
		end
		if (sck_rise)
		begin
			next_st.shift  = byte_in;
			next_st.bitcnt = st.bitcnt + 3'h1;
		end
		if (byte_done && !busy)
		begin
			if (st.bytecnt != HDR_DONE)
				next_st.bytecnt = st.bytecnt + 3'h1;
			case (st.bytecnt)
				3'h0: next_st.opcode = byte_in;
				3'h1: next_st.addr = {st.addr[7:0], byte_in};
				3'h2:
				begin
					next_st.addr = {st.addr[7:0], byte_in};
					next_st.page = byte_in;
				end
				3'h3:
				begin
					next_st.addr     = {st.addr[7:0], byte_in};
					next_st.start_lo = byte_in;
					next_st.wptr     = byte_in;
				end
				default:
				begin
					// Overwrite in a wrapping pointer keeps the last page worth
					if (st.opcode == OP_PROGRAM && !busy)
					begin
						next_st.pbuf[st.wptr] = byte_in;
						next_st.mask[st.wptr] = 1'b1;
						next_st.wptr = st.wptr + 8'h1;
						if (st.ndata != PAGE_FULL)
							next_st.ndata = st.ndata + 9'h1;
					end
				end
			endcase
		end
		// Commands finishing while busy are dropped whole
		if (cs_rise && !busy)
		begin
			case (st.opcode)
				OP_WREN:
					if (aligned)
						next_st.wr_en = 1'b1;
				OP_WRDI:
					if (aligned)
						next_st.wr_en = 1'b0;
				OP_PROGRAM:
				begin
					if (!aligned || st.bytecnt != HDR_DONE ||
						st.ndata == '0 || array_protect_bit_i)
						next_st.wr_en = 1'b0;
					else if (st.wr_en)
					begin
						go      = 1'b1;
						go_op   = AOP_PROGRAM;
						go_time = (st.ndata == 9'h1) ? BP_CYC : PP_CYC;
					end
				end
				OP_PAGE_ERASE, OP_BLK4, OP_BLK32_A, OP_BLK32_B:
				begin
					if (!aligned || st.bytecnt != HDR_DONE ||
						array_protect_bit_i)
						next_st.wr_en = 1'b0;
					else if (st.wr_en)
					begin
						go = 1'b1;
						if (st.opcode == OP_PAGE_ERASE)
						begin
							go_op   = AOP_ERASE_PAGE;
							go_time = PE_CYC;
						end
						else
						begin
							go_op   = (st.opcode == OP_BLK4) ?
								AOP_ERASE_4K : AOP_ERASE_32K;
							go_time = BLK_CYC;
						end
					end
				end
				OP_CHIP_A, OP_CHIP_B, OP_CHIP_C:
				begin
					if (!aligned || array_protect_bit_i)
						next_st.wr_en = 1'b0;
					else if (st.wr_en)
					begin
						go      = 1'b1;
						go_op   = AOP_ERASE_CHIP;
						go_time = CHP_CYC;
					end
				end
				default: ;
			endcase
		end
		if (go)
		begin
			next_st.state = ST_FILL;
			next_st.aop   = go_op;
			next_st.idx   = '0;
			next_st.timer = go_time;
			next_st.wr_en  = 1'b0;
			next_st.op_err = 1'b0;
		end
		case (st.state)
			ST_FILL:
			begin
				if (st.aop == AOP_PROGRAM)
				begin
					// Only received bytes go out; the rest stay erased
					push     = st.mask[a];
					cmd.op   = AOP_PROGRAM;
					cmd.addr = {st.addr[15:8], a} & ADDR_MASK;
					cmd.data = st.pbuf[a];
					if (!st.mask[a] || fifo_in_ready)
					begin
						next_st.mask[a] = 1'b0;
						next_st.idx     = st.idx + 8'h1;
						if (st.idx == LAST_IDX)
							next_st.state = ST_WAIT;
					end
				end
				else
				begin
					push     = 1'b1;
					cmd.op   = st.aop;
					cmd.data = ERASED_BYTE;
					case (st.aop)
						AOP_ERASE_PAGE:
							cmd.addr = {st.page, 8'h00} & ADDR_MASK;
						AOP_ERASE_4K:
							cmd.addr = st.addr & BLK4_MASK;
						AOP_ERASE_32K:
							cmd.addr = st.addr & BLK32_MASK;
						default:
							cmd.addr = '0;
					endcase
					if (fifo_in_ready)
						next_st.state = ST_WAIT;
				end
			end
			ST_WAIT:
				// Busy covers both the timebase and the array draining
				if (st.timer == '0 && !arr_valid_o)
					next_st.state = ST_IDLE;
			default: ;
		endcase
		if (busy && arr_fail_i)
			next_st.op_err = 1'b1;
	end

	always_ff @(posedge sys_clk_i or posedge reset_i)
	begin
		if (reset_i)
		begin
			st       <= '0;
			st.cs_d  <= 1'b1;
		end
		else
			st <= next_st;
	end

	// ========================================
	// Array command buffer
	cmd_fifo #(
		.WIDTH($bits(array_cmd_t)),
		.DEPTH(FIFO_DEPTH)
	) u_cmd_fifo (
		.sys_clk_i   (sys_clk_i),
		.reset_i     (reset_i),
		.in_valid_i  (push),
		.in_ready_o  (fifo_in_ready),
		.in_data_i   (cmd),
		.out_valid_o (arr_valid_o),
		.out_ready_i (arr_ready_i),
		.out_data_o  (arr_cmd_o)
	);

	assign status_o.busy                     = busy;
	assign status_o.write_enable_latch       = st.wr_en;
	assign status_o.erase_program_error_flag = st.op_err;

	// ========================================
	// Checks
	property p_start_needs_wr_en;
		@(posedge sys_clk_i) disable iff (reset_i)
		$rose(busy) |-> $past(st.wr_en) && !st.wr_en;
	endproperty
	a_start_needs_wr_en: assert property (p_start_needs_wr_en)
		else $error("Operation started without write enable");

	property p_start_not_protected;
		@(posedge sys_clk_i) disable iff (reset_i)
		$rose(busy) |-> !$past(array_protect_bit_i);
	endproperty
	a_start_not_protected: assert property (p_start_not_protected)
		else $error("Operation started while protected");

	property p_start_on_aligned_end;
		@(posedge sys_clk_i) disable iff (reset_i)
		$rose(busy) |-> $past(cs_rise) && $past(st.bitcnt) == 3'h0;
	endproperty
	a_start_on_aligned_end: assert property (p_start_on_aligned_end)
		else $error("Operation started off a byte boundary");

	property p_abort_clears_wr_en;
		@(posedge sys_clk_i) disable iff (reset_i)
		cs_rise && !busy && st.opcode == OP_PROGRAM && st.bitcnt != 3'h0
		|=> !st.wr_en && !busy;
	endproperty
	a_abort_clears_wr_en: assert property (p_abort_clears_wr_en)
		else $error("Unaligned program abort kept the latch");

	property p_page_wrap;
		@(posedge sys_clk_i) disable iff (reset_i)
		byte_done && st.bytecnt == HDR_DONE && st.opcode == OP_PROGRAM && !busy
		|=> st.wptr == 8'($past(st.wptr) + 8'h1);
	endproperty
	a_page_wrap: assert property (p_page_wrap)
		else $error("Page pointer did not advance by one");

	property p_fail_sets_flag;
		@(posedge sys_clk_i) disable iff (reset_i)
		busy && arr_fail_i |=> st.op_err [*2];
	endproperty
	a_fail_sets_flag: assert property (p_fail_sets_flag)
		else $error("Array failure not flagged");

	property p_block_addr_aligned;
		@(posedge sys_clk_i) disable iff (reset_i)
		push && cmd.op == AOP_ERASE_4K |-> cmd.addr[11:0] == 12'h000;
	endproperty
	a_block_addr_aligned: assert property (p_block_addr_aligned)
		else $error("Block erase address not block aligned");

	property p_busy_holds;
		@(posedge sys_clk_i) disable iff (reset_i)
		busy && st.timer > 32'h1 |=> busy;
	endproperty
	a_busy_holds: assert property (p_busy_holds)
		else $error("Busy dropped before the timebase expired");

	property p_no_restart;
		@(posedge sys_clk_i) disable iff (reset_i)
		busy |=> !$rose(busy) && st.timer <= $past(st.timer);
	endproperty
	a_no_restart: assert property (p_no_restart)
		else $error("Second operation started while busy");
endmodule : spi_flash_program_erase_sequencer

// *** tb/spi_flash_program_erase_sequencer_test.sv ***
`timescale 1ns/1ps
module spi_flash_program_erase_sequencer_test;
	import flash_seq_pkg::*;
	logic       sys_clk_i;
	logic       reset_i;
	logic       array_protect_bit_i;
	logic       arr_ready_i;
	logic       arr_fail_i;
	logic       arr_valid_o;
	spi_in_t    spi;
	array_cmd_t arr_cmd_o;
	status_t    status_o;
	array_cmd_t got[$];
	int         n_mismatch;
	int         n_tests;
	logic [7:0] q[$];
	int         k;
	// ========================================
	// Parts
	spi_host_model i_host (
		.sys_clk_i (sys_clk_i),
		.spi_o     (spi)
	);
	// Short times give every operation a 125-cycle timebase
	spi_flash_program_erase_sequencer #(
		.PAGE_PROGRAM_TIME_US        (1),
		.SINGLE_BYTE_PROGRAM_TIME_US (1),
		.PAGE_ERASE_TIME_US          (1),
		.BLOCK_ERASE_TIME_US         (1),
		.WHOLE_ARRAY_ERASE_TIME_US   (1)
	) i_dut (
		.sys_clk_i           (sys_clk_i),
		.reset_i             (reset_i),
		.spi_i               (spi),
		.array_protect_bit_i (array_protect_bit_i),
		.arr_ready_i         (arr_ready_i),
		.arr_fail_i          (arr_fail_i),
		.arr_valid_o         (arr_valid_o),
		.arr_cmd_o           (arr_cmd_o),
		.status_o            (status_o)
	);
	initial
	begin
		sys_clk_i = 1'b0;
		forever #4 sys_clk_i = ~sys_clk_i;
	end
	always @(posedge sys_clk_i)
		if (arr_valid_o === 1'b1 && arr_ready_i === 1'b1)
			got.push_back(arr_cmd_o);
	// ========================================
	// Helpers
	task automatic end_of_test;
		$display("mismatches %0d comparisons %0d", n_mismatch, n_tests);
		if (n_mismatch == 0 && n_tests > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : end_of_test
	task automatic chk(input logic [31:0] a, input logic [31:0] e);
		n_tests++;
		if (a !== e)
		begin
			n_mismatch++;
			$display("ERROR t=%0t got %h exp %h", $time, a, e);
		end
	endtask : chk
	task automatic wait_idle;
		int i;
		for (i = 0; i < 4000 && status_o.busy !== 1'b0; i++)
			@(posedge sys_clk_i);
		if (i == 4000)
		begin
			n_mismatch++;
			end_of_test();
		end
	endtask : wait_idle
	task automatic wren;
		i_host.xfer('{OP_WREN}, 8);
		repeat (3) @(posedge sys_clk_i);
		chk(status_o.write_enable_latch, 1);
	endtask : wren
	task automatic run(input logic [7:0] b[$], input int nb, input int n,
		input logic f, input int stall);
		got.delete();
		i_host.xfer(b, nb);
		repeat (3) @(posedge sys_clk_i);
		chk(status_o.busy, n > 0);
		chk(status_o.write_enable_latch, 0);
		arr_fail_i <= f;
		@(posedge sys_clk_i);
		arr_fail_i <= 1'b0;
		repeat (stall) @(posedge sys_clk_i);
		arr_ready_i <= 1'b1;
		wait_idle();
		chk(got.size(), n);
		if (n > 0)
			chk(status_o.erase_program_error_flag, f);
	endtask : run
	task automatic want(input array_op_t op, input logic [15:0] a,
		input logic [7:0] d);
		int i;
		int hit;
		hit = 0;
		for (i = 0; i < got.size(); i++)
			if (got[i].op === op && got[i].addr === a && got[i].data === d)
				hit = 1;
		chk(hit, 1);
	endtask : want
	task automatic ab(input logic [7:0] b[$], input int nb, input logic we,
		input logic pr);
		if (we)
			wren();
		array_protect_bit_i <= pr;
		run(b, nb, 0, 1'b0, 0);
		array_protect_bit_i <= 1'b0;
	endtask : ab
	task automatic er(input logic [7:0] b[$], input int nb,
		input array_op_t op, input logic [15:0] a, input logic f);
		wren();
		run(b, nb, 1, f, 0);
		want(op, a, ERASED_BYTE);
	endtask : er
	// ========================================
	// Scenarios
	task automatic t_wrap;
		wren();
		run('{OP_PROGRAM, 8'h00, 8'h12, 8'hfe, 8'ha1, 8'hb2, 8'hc3}, 56, 3,
			1'b0, 0);
		want(AOP_PROGRAM, 16'h12fe, 8'ha1);
		want(AOP_PROGRAM, 16'h12ff, 8'hb2);
		want(AOP_PROGRAM, 16'h1200, 8'hc3);
		wren();
		run('{OP_PROGRAM, 8'h00, 8'h01, 8'h05, 8'h3c}, 40, 1, 1'b1, 0);
		want(AOP_PROGRAM, 16'h0105, 8'h3c);
	endtask : t_wrap
	task automatic t_overflow;
		q = '{OP_PROGRAM, 8'h00, 8'h03, 8'h00};
		for (k = 0; k < 258; k++)
			q.push_back(k < 256 ? 8'h11 : 8'h77);
		wren();
		arr_ready_i <= 1'b0;
		// Array stalls so the command FIFO fills and refuses
		run(q, 2096, 256, 1'b0, 200);
		want(AOP_PROGRAM, 16'h0300, 8'h77);
		want(AOP_PROGRAM, 16'h0301, 8'h77);
		want(AOP_PROGRAM, 16'h0302, 8'h11);
		want(AOP_PROGRAM, 16'h03ff, 8'h11);
	endtask : t_overflow
	task automatic t_abort;
		ab('{OP_PROGRAM, 8'h00, 8'h00, 8'h00, 8'h55}, 40, 0, 0);
		ab('{OP_PROGRAM, 8'h00, 8'h00, 8'h00, 8'h55}, 39, 1, 0);
		ab('{OP_PROGRAM, 8'h00, 8'h00, 8'h00}, 32, 1, 0);
		ab('{OP_PROGRAM, 8'h00, 8'h00}, 24, 1, 0);
		ab('{OP_PROGRAM, 8'h00, 8'h00, 8'h00, 8'h55}, 40, 1, 1);
		ab('{OP_BLK4, 8'h00, 8'h10}, 24, 1, 0);
		ab('{OP_BLK4, 8'h00, 8'h10, 8'h00, 8'h00}, 33, 1, 0);
		ab('{OP_BLK32_B, 8'h00, 8'h10, 8'h00}, 32, 1, 1);
		ab('{OP_CHIP_C, 8'h00}, 12, 1, 0);
		ab('{OP_CHIP_A}, 8, 1, 1);
		wren();
		i_host.xfer('{OP_WRDI}, 8);
		ab('{OP_PROGRAM, 8'h00, 8'h00, 8'h00, 8'h55}, 40, 0, 0);
		i_host.xfer('{OP_WREN, 8'h00}, 15);
		repeat (3) @(posedge sys_clk_i);
		chk(status_o.write_enable_latch, 0);
	endtask : t_abort
	task automatic t_erase;
		er('{OP_PAGE_ERASE, 8'h00, 8'h34, 8'h00}, 32, AOP_ERASE_PAGE,
			16'h3400, 0);
		er('{OP_BLK4, 8'h01, 8'hab, 8'hcd}, 32, AOP_ERASE_4K,
			16'h2000, 0);
		er('{OP_BLK32_A, 8'h00, 8'h7f, 8'hff}, 32, AOP_ERASE_32K,
			16'h0000, 0);
		er('{OP_BLK32_B, 8'h00, 8'h12, 8'h34, 8'hff}, 40, AOP_ERASE_32K,
			16'h0000, 1);
		er('{OP_CHIP_A}, 8, AOP_ERASE_CHIP, 16'h0000, 0);
		er('{OP_CHIP_B}, 8, AOP_ERASE_CHIP, 16'h0000, 1);
		er('{OP_CHIP_C, 8'h99}, 16, AOP_ERASE_CHIP, 16'h0000, 0);
	endtask : t_erase
	task automatic t_busy;
		wren();
		got.delete();
		i_host.xfer('{OP_PAGE_ERASE, 8'h00, 8'h05, 8'h00}, 32);
		i_host.xfer('{OP_WREN}, 8);
		i_host.xfer('{OP_CHIP_A}, 8);
		wait_idle();
		chk(status_o.write_enable_latch, 0);
		chk(got.size(), 1);
		want(AOP_ERASE_PAGE, 16'h0500, ERASED_BYTE);
	endtask : t_busy
	// ========================================
	// Main sequence
	initial
	begin
		n_mismatch = 0;
		n_tests = 0;
		reset_i = 1'b1;
		array_protect_bit_i = 1'b0;
		arr_ready_i = 1'b1;
		arr_fail_i = 1'b0;
		repeat (12) @(posedge sys_clk_i);
		reset_i <= 1'b0;
		repeat (2) @(posedge sys_clk_i);
		chk({arr_valid_o, status_o}, 4'h0);
		t_wrap();
		t_overflow();
		t_abort();
		t_erase();
		t_busy();
		end_of_test();
	end
endmodule : spi_flash_program_erase_sequencer_test

// *** tb/spi_host_model.sv ***
`timescale 1ns/1ps
// ========================================
// Serial host: chip select, mode 0 clock, data
module spi_host_model
	import flash_seq_pkg::*;
(
	input  wire logic sys_clk_i,
	output spi_in_t   spi_o
);
	initial
	begin
		spi_o = '{cs_n: 1'b1, sck: 1'b0, mosi: 1'b0};
	end
	// Idle data toggles so stale bits never look valid
	always @(posedge sys_clk_i)
		if (spi_o.cs_n)
			spi_o.mosi <= ~spi_o.mosi;
	// MSB first; a short count ends the frame off a byte boundary
	task automatic xfer(input logic [7:0] q[$], input int nb);
		int i;
		@(posedge sys_clk_i);
		spi_o.cs_n <= 1'b0;
		for (i = 0; i < nb; i++)
		begin
			@(posedge sys_clk_i);
			spi_o.sck  <= 1'b0;
			spi_o.mosi <= q[i / 8][7 - (i % 8)];
			@(posedge sys_clk_i);
			spi_o.sck <= 1'b1;
		end
		@(posedge sys_clk_i);
		spi_o.sck <= 1'b0;
		@(posedge sys_clk_i);
		spi_o.cs_n <= 1'b1;
		@(posedge sys_clk_i);
	endtask : xfer
endmodule : spi_host_model
